//--- logic/osf_filter.sv
// ----------------------------------------------------------------
// Overview of operation
// - the select code maps 000 to no averaging, 001..110 to ratio 2..64, 111 is invalid.
// - sample strobes are paced so throughput is 200 kSPS divided by the ratio.
// - the first sample of a burst is taken on the rising conversion-start edge.
// - remaining samples of the burst come from an internal sample strobe.
// - all samples of a channel in a burst are averaged.
// - exactly one 16-bit word per channel leaves for each conversion start taken in idle; starts during a burst are ignored.
// - results are 16-bit two's complement for every range and channel.
// ----------------------------------------------------------------
`include "osf_defs.svh"

module osf_filter
   import osf_pkg::*;
#(
   parameter int NCH = 8,
   parameter int DW = 16,
   parameter int FIFO_DEPTH = 8,
   parameter int SAMPLE_CYC = `OSF_SAMPLE_CYC
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic srst_i,
   // pins
   input wire logic [2:0] oversample_ratio_select_i,
   input wire logic conv_start_first_half_i,
   input wire logic conv_start_second_half_i,
   // converter core
   output logic sample_strobe_o,
   input wire logic conv_done_i,
   input wire logic [NCH*DW-1:0] conv_data_i,
   // filtered results
   output logic res_valid_o,
   input wire logic res_ready_i,
   output logic [2:0] res_chan_o,
   output logic [DW-1:0] res_data_o,
   output logic busy_o,
   output logic sel_invalid_o
);
   localparam int AW = DW + 6;
   localparam int CW = $clog2(SAMPLE_CYC + 1);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [2:0] shift_of(input logic [2:0] sel);
      shift_of = (sel == `OSF_SEL_BAD) ? `OSF_SEL_NONE : sel;
   endfunction : shift_of

   osf_state_t st_ff;
   logic [2:0] ssel1_ff, ssel2_ff, sel_ff;
   logic [1:0] csa_ff, csb_ff;
   logic cs_prev_ff;
   logic cs_now;
   logic [6:0] left_ff;
   logic [CW-1:0] pace_ff;
   logic [AW-1:0] acc_ff [NCH];
   logic [2:0] och_ff;
   logic [2:0] shamt;
   logic fifo_ready;
   logic [AW-1:0] avg;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         ssel1_ff <= '0;
         ssel2_ff <= '0;
         csa_ff <= '0;
         csb_ff <= '0;
         cs_prev_ff <= 1'b0;
      end
      else
      begin
         ssel1_ff <= oversample_ratio_select_i;
         ssel2_ff <= ssel1_ff;
         csa_ff <= {csa_ff[0], conv_start_first_half_i};
         csb_ff <= {csb_ff[0], conv_start_second_half_i};
         cs_prev_ff <= cs_now;
      end
   end
   // either half starts all channels; host ties them when averaging
   assign cs_now = csa_ff[1] | csb_ff[1];
   assign shamt = shift_of(sel_ff);

   // ----------------------------------------------------------------
   // burst control
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         st_ff <= OSF_IDLE;
         sel_ff <= '0;
         left_ff <= '0;
         pace_ff <= '0;
         sample_strobe_o <= 1'b0;
         och_ff <= '0;
         busy_o <= 1'b0;
         sel_invalid_o <= 1'b0;
      end
      else
      begin
         sample_strobe_o <= 1'b0;
         sel_invalid_o <= (ssel2_ff == `OSF_SEL_BAD);
         if (pace_ff != '0)
         begin
            pace_ff <= pace_ff - 1'b1;
         end
         case (st_ff)
            OSF_IDLE:
            begin
               busy_o <= 1'b0;
               if (cs_now && !cs_prev_ff && (pace_ff == '0))
               begin
                  sel_ff <= ssel2_ff;
                  left_ff <= 7'(1) << shift_of(ssel2_ff);
                  sample_strobe_o <= 1'b1;
                  pace_ff <= CW'(SAMPLE_CYC - 1);
                  busy_o <= 1'b1;
                  st_ff <= OSF_WAIT;
               end
            end
            OSF_WAIT:
            begin
               if (conv_done_i)
               begin
                  left_ff <= left_ff - 1'b1;
                  st_ff <= OSF_ACC;
               end
            end
            OSF_ACC:
            begin
               if (left_ff == '0)
               begin
                  och_ff <= '0;
                  st_ff <= OSF_OUT;
               end
               else if (pace_ff == '0)
               begin
                  sample_strobe_o <= 1'b1;
                  pace_ff <= CW'(SAMPLE_CYC - 1);
                  st_ff <= OSF_WAIT;
               end
            end
            OSF_OUT:
            begin
               if (fifo_ready)
               begin
                  och_ff <= och_ff + 1'b1;
                  if (och_ff == 3'(NCH - 1))
                  begin
                     st_ff <= OSF_IDLE;
                  end
               end
            end
            default:
            begin
               st_ff <= OSF_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // accumulators
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i)
   begin
      for (int i = 0; i < NCH; i++)
      begin
         if (srst_i || (st_ff == OSF_IDLE))
         begin
            acc_ff[i] <= '0;
         end
         else if ((st_ff == OSF_WAIT) && conv_done_i)
         begin
            // sign-extended sum, six guard bits cover ratio 64
            acc_ff[i] <= acc_ff[i] + {{(AW-DW){conv_data_i[i*DW+DW-1]}}, conv_data_i[i*DW +: DW]};
         end
      end
   end

   // arithmetic shift keeps two's complement
   assign avg = AW'($signed(acc_ff[och_ff]) >>> shamt);

   // ----------------------------------------------------------------
   // result fifo, stalls the output walk when full
   // ----------------------------------------------------------------
   logic [DW+2:0] fifo_out;
   logic fifo_valid;
   osf_fifo #(.W(DW + 3), .D(FIFO_DEPTH)) u_fifo (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .in_valid_i(st_ff == OSF_OUT),
      .in_ready_o(fifo_ready),
      .in_data_i({och_ff, avg[DW-1:0]}),
      .out_valid_o(fifo_valid),
      .out_ready_i(res_ready_i && !(res_valid_o && !res_ready_i) || !res_valid_o),
      .out_data_o(fifo_out)
   );

   // registered output stage
   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         res_valid_o <= 1'b0;
         res_chan_o <= '0;
         res_data_o <= '0;
      end
      else if (!res_valid_o || res_ready_i)
      begin
         res_valid_o <= fifo_valid;
         res_chan_o <= fifo_out[DW+2:DW];
         res_data_o <= fifo_out[DW-1:0];
      end
   end
endmodule : osf_filter

//--- logic/osf_defs.svh
`ifndef OSF_DEFS_SVH
`define OSF_DEFS_SVH

// ----------------------------------------------------------------
// ratio select codes
// ----------------------------------------------------------------
`define OSF_SEL_NONE 3'h0
`define OSF_SEL_X64 3'h6
`define OSF_SEL_BAD 3'h7

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define OSF_CLK_MHZ 125
`define OSF_BASE_KSPS 200
// cycles between internal sample strobes at base throughput
`define OSF_SAMPLE_CYC ((`OSF_CLK_MHZ * 1000) / `OSF_BASE_KSPS)

`endif

//--- logic/osf_pkg.sv
package osf_pkg;
   typedef enum logic [1:0] {OSF_IDLE, OSF_WAIT, OSF_ACC, OSF_OUT} osf_state_t;
endpackage : osf_pkg

//--- logic/osf_fifo.sv
// ----------------------------------------------------------------
// result fifo
// ----------------------------------------------------------------
module osf_fifo #(
   parameter int W = 19,
   parameter int D = 8
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic srst_i,
   // write side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   // read side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_ff [D];
   logic [AW-1:0] wp_ff;
   logic [AW-1:0] rp_ff;
   logic [AW:0] cnt_ff;
   logic wr;
   logic rd;

   // handshakes
   assign wr = in_valid_i && (cnt_ff != (AW+1)'(D));
   assign rd = out_ready_i && (cnt_ff != '0);
   assign in_ready_o = (cnt_ff != (AW+1)'(D));
   assign out_valid_o = (cnt_ff != '0);
   assign out_data_o = mem_ff[rp_ff];

   // storage
   always_ff @(posedge mclk_i)
   begin
      if (wr)
      begin
         mem_ff[wp_ff] <= in_data_i;
      end
   end

   // pointers and fill level
   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         wp_ff <= '0;
         rp_ff <= '0;
         cnt_ff <= '0;
      end
      else
      begin
         if (wr)
         begin
            wp_ff <= (wp_ff == AW'(D-1)) ? '0 : wp_ff + 1'b1;
         end
         if (rd)
         begin
            rp_ff <= (rp_ff == AW'(D-1)) ? '0 : rp_ff + 1'b1;
         end
         cnt_ff <= cnt_ff + (AW+1)'(wr) - (AW+1)'(rd);
      end
   end
endmodule : osf_fifo

//--- verif/osf_chk.sv
module osf_chk
   import osf_pkg::*;
#(
   parameter int SAMPLE_CYC = 20
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic srst_i,
   // pins
   input wire logic [2:0] oversample_ratio_select_i,
   input wire logic conv_start_first_half_i,
   input wire logic conv_start_second_half_i,
   // outputs
   input wire logic sample_strobe_o,
   input wire logic res_valid_o,
   input wire logic res_ready_i,
   input wire logic [2:0] res_chan_o,
   input wire logic [15:0] res_data_o,
   input wire logic busy_o,
   input wire logic sel_invalid_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (srst_i);
   logic [2:0] ch_ff;
   logic [15:0] gap_ff;
   // channel expected on the next word
   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
         ch_ff <= 3'h0;
      else if (res_valid_o && res_ready_i)
         ch_ff <= ch_ff + 3'h1;
   end
   // cycles since last strobe, all ones means none yet; wide enough for the full pace count
   always_ff @(posedge mclk_i)
   begin
      if (srst_i || sample_strobe_o)
         gap_ff <= srst_i ? 16'hffff : 16'h0000;
      else if (gap_ff != 16'hffff)
         gap_ff <= gap_ff + 16'h0001;
   end
   sequence s_start;
      $rose(conv_start_first_half_i | conv_start_second_half_i) && !busy_o;
   endsequence
   sequence s_stall;
      res_valid_o && !res_ready_i;
   endsequence
   a_start_strobe: assert property (s_start |-> ##[1:40] sample_strobe_o) else $error("no strobe");
   a_strobe_pulse: assert property (sample_strobe_o |=> !sample_strobe_o [*8]) else $error("strobe");
   a_strobe_busy: assert property (sample_strobe_o |=> busy_o) else $error("idle strobe");
   a_strobe_pace: assert property (sample_strobe_o && gap_ff != 16'hffff |-> gap_ff >= SAMPLE_CYC - 1)
      else $error("pace");
   a_flag_set: assert property ((oversample_ratio_select_i == 3'h7) [*4] |-> sel_invalid_o) else $error("flag");
   a_flag_clear: assert property ((oversample_ratio_select_i != 3'h7) [*4] |-> !sel_invalid_o) else $error("flag");
   a_word_hold: assert property (s_stall |=> res_valid_o && $stable(res_data_o) && $stable(res_chan_o))
      else $error("word dropped");
   a_chan_order: assert property (res_valid_o |-> res_chan_o == ch_ff) else $error("channel order");
endmodule : osf_chk

bind osf_filter osf_chk #(.SAMPLE_CYC(SAMPLE_CYC)) u_chk (.mclk_i(mclk_i), .srst_i(srst_i),
   .oversample_ratio_select_i(oversample_ratio_select_i), .conv_start_first_half_i(conv_start_first_half_i),
   .conv_start_second_half_i(conv_start_second_half_i), .sample_strobe_o(sample_strobe_o),
   .res_valid_o(res_valid_o), .res_ready_i(res_ready_i), .res_chan_o(res_chan_o), .res_data_o(res_data_o),
   .busy_o(busy_o), .sel_invalid_o(sel_invalid_o));

//--- verif/osf_core_model.sv
module osf_core_model (
   // clock and reset
   input wire logic mclk_i,
   input wire logic srst_i,
   // converter side
   input wire logic strobe_i,
   input wire logic [3:0] lat_i,
   output logic done_o,
   output logic [127:0] data_o,
   output logic [15:0] cnt_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] w_ff;
   logic run_ff;
   logic [127:0] d_ff;
   // one conversion per strobe, done_o pulses lat_i + 2 cycles after the strobe
   always_ff @(posedge mclk_i)
   begin
      done_o <= 1'b0;
      if (srst_i)
      begin
         run_ff <= 1'b0;
         cnt_o <= 16'h0000;
      end
      else if (strobe_i)
      begin
         run_ff <= 1'b1;
         w_ff <= lat_i;
      end
      else if (run_ff && w_ff != 4'h0)
         w_ff <= w_ff - 4'h1;
      else if (run_ff)
      begin
         run_ff <= 1'b0;
         done_o <= 1'b1;
         cnt_o <= cnt_o + 16'h0001;
         for (int k = 0; k < 8; k++)
            d_ff[k*16+:16] <= 16'(k * 256 - 768) + cnt_o;
      end
   end
   // samples valid only with done, inverted otherwise
   assign data_o = done_o ? d_ff : ~d_ff;
endmodule : osf_core_model

//--- verif/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import osf_pkg::*;
   localparam int SC = 20;
   logic mclk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [2:0] sel = 3'h0;
   logic cs = 1'b0;
   logic rdy = 1'b0;
   logic [3:0] lat = 4'h1;
   logic strobe, done, vld, busy, inval;
   logic [127:0] cdata;
   logic [2:0] ch;
   logic [15:0] rdata, cnt;
   int failures = 0;
   int n_compared = 0;
   int cyc = 0;
   int n_strobe = 0;
   osf_filter #(.SAMPLE_CYC(SC)) dut (.mclk_i(mclk_i), .srst_i(srst_i), .oversample_ratio_select_i(sel),
      .conv_start_first_half_i(cs), .conv_start_second_half_i(cs), .sample_strobe_o(strobe),
      .conv_done_i(done), .conv_data_i(cdata), .res_valid_o(vld), .res_ready_i(rdy), .res_chan_o(ch),
      .res_data_o(rdata), .busy_o(busy), .sel_invalid_o(inval));
   osf_core_model model (.mclk_i(mclk_i), .srst_i(srst_i), .strobe_i(strobe), .lat_i(lat), .done_o(done),
      .data_o(cdata), .cnt_o(cnt));
   initial forever #4 mclk_i = ~mclk_i;
   // strobe count and hang limit
   always @(posedge mclk_i)
   begin
      cyc++;
      n_strobe += (strobe === 1'b1);
      if (cyc == 30000)
      begin
         failures++;
         conclude();
      end
   end
   task cmp(string what, logic [15:0] e, logic [15:0] g);
      n_compared++;
      if (e !== g)
      begin
         failures++;
         $display("mismatch %s exp %h got %h", what, e, g);
      end
   endtask : cmp
   task conclude;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : conclude
   // one start (a second one during the burst when refire is set), collect eight words
   task burst(input logic [2:0] c, input bit refire, input bit stall);
      int n, s0, w;
      logic [15:0] c0;
      n = (c == 3'h0 || c == 3'h7) ? 1 : 1 << c;
      sel <= c;
      repeat (SC + 8) @(posedge mclk_i);
      c0 = cnt;
      s0 = n_strobe;
      rdy <= !stall;
      cs <= 1'b1;
      repeat (6) @(posedge mclk_i);
      cs <= 1'b0;
      if (refire)
      begin
         repeat (40) @(posedge mclk_i);
         cs <= 1'b1;
         repeat (6) @(posedge mclk_i);
         cs <= 1'b0;
      end
      for (w = 0; stall && vld !== 1'b1 && w < 5000; w++)
         @(posedge mclk_i);
      repeat (stall ? 20 : 1) @(posedge mclk_i);
      rdy <= 1'b1;
      for (int k = 0; k < 8; k++)
      begin
         w = 0;
         do
            @(posedge mclk_i);
         while (vld !== 1'b1 && ++w < 5000);
         cmp("chan", 16'(k), 16'(ch));
         cmp("data", 16'(k * 256 - 768) + c0 + 16'((n - 1) / 2), rdata);
      end
      repeat (20) @(posedge mclk_i);
      cmp("extra word", 16'h0000, 16'(vld));
      cmp("strobes", 16'(n), 16'(n_strobe - s0));
      cmp("invalid", 16'(c == 3'h7), 16'(inval));
      $display("burst code %0d ended", c);
   endtask : burst
   task t_reset;
      cmp("idle outputs", 16'h0000, 16'({strobe, vld, busy, inval}));
      $display("reset test ended");
   endtask : t_reset
   task t_ratios;
      for (int c = 0; c < 8; c++)
         burst(3'(c), 1'b0, 1'b0);
   endtask : t_ratios
   task t_stall;
      lat <= 4'h6;
      burst(3'h2, 1'b0, 1'b1);
      lat <= 4'h1;
   endtask : t_stall
   task t_refire;
      burst(3'h3, 1'b1, 1'b0);
   endtask : t_refire
   initial
   begin
      repeat (3) @(posedge mclk_i);
      srst_i <= 1'b0;
      @(posedge mclk_i);
      t_reset();
      t_ratios();
      t_stall();
      t_refire();
      conclude();
   end
endmodule : tb_top
